// File: core/msd_decoder.sv
// memory space decoder top: selects, routing and page registers
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Overview of operation
// - main flash decoded as eight 16K sectors
// - secondary flash decoded as three 8K segments, fourth unmapped
// - sectors two to seven paged in upper program half
// - sectors zero and one in lower half, page ignored
// - secondary segments upper data half, sram and control lower
// - core internal registers are not external, sharing addresses is fine
// - sram 0000-1FFF, control block 2000-20FF, any page
// - sector one at 4000-7FFF, no page
// - sector pairs by page 0,1,2 at 8000-BFFF and C000-FFFF
// - segments zero to two at 8000, A000, C000, page ignored
// - routing register rewrite takes effect from the clock edge that samples it, for bus cycles after that edge
// - byte programming allowed, erase only per sector
// - routing bits: data main, data sec, fetch main, fetch sec, fetch sram
// - reset reloads routing bits from default, clears peripheral enable
// - secondary flash wins over main flash
// - sram, control, peripheral window win over flash
module msd_decoder (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // core external bus
  input  wire logic [15:0]            addr,
  input  wire logic                   data_rd,
  input  wire logic                   data_wr,
  input  wire logic                   program_fetch_strobe,
  input  wire logic [7:0]             wdata,
  // nonvolatile routing default
  input  wire logic [4:0]             nv_routing,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output      logic [7:0]             reg_rdata,
  // memory selects
  output      logic [7:0]             main_flash_sector_select,
  output      logic [3:0]             secondary_flash_segment_select,
  output      logic                   sram_select,
  output      logic                   ctrl_select,
  output      logic                   peripheral_window_select,
  // flash operation strobes and page register value
  output      logic                   flash_byte_program,
  output      logic                   flash_sector_erase,
  output      logic [7:0]             page_value
);
  import msd_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] routing;
    logic [7:0] page;
    logic [7:0] rdata;
    logic [7:0] main_sel;
    logic [3:0] sec_sel;
    logic       sram_sel;
    logic       ctrl_sel;
    logic       pwin_sel;
    logic       prog;
    logic       erase;
    logic       wr_blocked;
    logic       nv_load;
  } msd_state_t;

  msd_state_t state;
  msd_state_t next_state;
  logic [7:0] main_hit;
  msd_cycle_t cyc;
  logic       hit_sram;
  logic       hit_ctrl;
  logic       hit_pwin;
  logic [3:0] hit_seg;
  logic       hi_prio;
  logic       sec_any;
  logic       main_ok;
  logic       sec_ok;

  msd_main_flash_dec u_main_dec (
    .addr (addr),
    .page (state.page),
    .hit  (main_hit)
  );

  // ****************************************
  // raw region decode
  // ****************************************
  // sram and control ranges
  assign hit_sram = (addr >= SRAM_LO) && (addr <= SRAM_HI);
  assign hit_ctrl = (addr >= CTRL_LO) && (addr <= CTRL_HI);
  assign hit_pwin = state.routing[RT_PERIPHERAL_WINDOW_ENABLE] && (addr >= PWIN_LO) && (addr <= PWIN_HI);
  genvar s;
  generate
    for (s = 0; s < NUM_SEG; s++) begin : g_seg
      if (s < NUM_SEG_MAP) begin : g_map
        assign hit_seg[s] = addr[15] && (addr[14:SEG_SHIFT] == 2'(s));
      end else begin : g_unmap
        // fourth segment kept unmapped in this map
        assign hit_seg[s] = 1'b0;
      end
    end
  endgenerate

  // classify the bus cycle
  always_comb begin
    if (program_fetch_strobe) begin
      cyc = MSD_FETCH;
    end else if (data_rd || data_wr) begin
      cyc = MSD_DATA;
    end else begin
      cyc = MSD_IDLE;
    end
  end

  always_comb begin
    main_ok = 1'b0;
    sec_ok  = 1'b0;
    case (cyc)
      MSD_FETCH: begin
        main_ok = state.routing[RT_MAIN_PRG];
        sec_ok  = state.routing[RT_SEC_PRG];
      end
      MSD_DATA: begin
        main_ok = state.routing[RT_MAIN_DAT];
        sec_ok  = state.routing[RT_SEC_DAT];
      end
      default: begin
        main_ok = 1'b0;
        sec_ok  = 1'b0;
      end
    endcase
  end

  // control block and sram are data space only, except sram fetch bit
  // lower half for sram and control, upper for segments
  assign hi_prio = (cyc == MSD_DATA && (hit_sram || hit_ctrl || hit_pwin))
                   || (cyc == MSD_FETCH && hit_sram && state.routing[RT_SRAM_PRG]);
  assign sec_any = sec_ok && (|hit_seg);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.nv_load = 1'b0;
    // first cycle after reset loads default routing
    if (state.nv_load) begin
      next_state.routing = {3'b000, nv_routing};
    end
    if (reg_wr && reg_addr == OFF_PAGE) begin
      next_state.page = reg_wdata;
    end
    if (reg_wr && reg_addr == OFF_ROUTING) begin
      next_state.routing = reg_wdata & 8'h9F;
    end
    // register read data, valid the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        OFF_ROUTING: next_state.rdata = state.routing;
        OFF_PAGE:    next_state.rdata = state.page;
        OFF_STATUS:  next_state.rdata = {7'h00, state.wr_blocked};
        default:     next_state.rdata = 8'h00;
      endcase
    end else begin
      next_state.rdata = 8'h00;
    end
    // sram, control and window beat flash
    next_state.sram_sel = hit_sram && (cyc == MSD_DATA
                          || (cyc == MSD_FETCH && state.routing[RT_SRAM_PRG]));
    next_state.ctrl_sel = hit_ctrl && (cyc == MSD_DATA);
    next_state.pwin_sel = hit_pwin && (cyc == MSD_DATA);
    next_state.sec_sel  = (hi_prio || !sec_ok) ? 4'h0 : hit_seg;
    next_state.main_sel = (hi_prio || sec_any || !main_ok) ? 8'h00 : main_hit;
    // byte program on data write, sector erase via command data
    // writes during fetch are never routed to flash
    next_state.prog  = 1'b0;
    next_state.erase = 1'b0;
    if (data_wr && cyc == MSD_DATA && !hi_prio && ((sec_any) || (main_ok && |main_hit))) begin
      next_state.prog  = (wdata != 8'h30);
      next_state.erase = (wdata == 8'h30);
    end
    // sticky note of an upper-half write that found no routed flash
    if (data_wr && cyc == MSD_DATA && !hi_prio && !sec_any && !(main_ok && |main_hit)
        && addr[15]) begin
      next_state.wr_blocked = 1'b1;
    end else if (reg_wr && reg_addr == OFF_STATUS) begin
      next_state.wr_blocked = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset clears peripheral enable, arms default load
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state         <= '0;
      state.page    <= PAGE_RESET;
      state.routing <= {3'b000, RT_NV_DEFAULT};
      state.nv_load <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata                      = state.rdata;
  assign main_flash_sector_select       = state.main_sel;
  assign secondary_flash_segment_select = state.sec_sel;
  assign sram_select                    = state.sram_sel;
  assign ctrl_select                    = state.ctrl_sel;
  assign peripheral_window_select       = state.pwin_sel;
  assign flash_byte_program             = state.prog;
  assign flash_sector_erase             = state.erase;
  assign page_value                     = state.page;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence routed_write_s;
    reg_wr && reg_addr == OFF_ROUTING;
  endsequence

  // first cycle after reset with no routing write beside it
  sequence nv_load_s;
    state.nv_load && !(reg_wr && reg_addr == OFF_ROUTING);
  endsequence

  // write cycle in the upper half that no routed flash takes
  sequence blocked_write_s;
    cyc == MSD_DATA && data_wr && addr[15] && !sec_any && !(main_ok && |main_hit);
  endsequence

  routing_write_a: assert property (
    routed_write_s |=> state.routing == ($past(reg_wdata) & 8'h9F))
    else $error("routing write lost");
  routing_hold_a: assert property (
    !state.nv_load && !(reg_wr && reg_addr == OFF_ROUTING) |=> $stable(state.routing))
    else $error("routing changed without a write");
  routing_load_a: assert property (
    nv_load_s |=> state.routing == {3'b000, $past(nv_routing)})
    else $error("default routing not loaded");
  sec_over_main_a: assert property (
    |secondary_flash_segment_select |-> !(|main_flash_sector_select))
    else $error("secondary and main both selected");
  sram_prio_a: assert property (
    sram_select |-> !(|main_flash_sector_select) && !(|secondary_flash_segment_select))
    else $error("flash selected with sram");
  ctrl_prio_a: assert property (
    ctrl_select |-> !(|main_flash_sector_select) && !(|secondary_flash_segment_select))
    else $error("flash selected with control block");
  pwin_prio_a: assert property (
    peripheral_window_select |-> !(|main_flash_sector_select) && !(|secondary_flash_segment_select))
    else $error("flash selected with window");
  pwin_enable_a: assert property (
    peripheral_window_select |-> $past(state.routing[RT_PERIPHERAL_WINDOW_ENABLE]))
    else $error("window selected while disabled");
  ctrl_range_a: assert property (
    data_rd && addr == 16'h20FF |=> ctrl_select)
    else $error("control block not selected");
  sram_range_a: assert property (
    cyc == MSD_DATA && addr <= SRAM_HI |=> sram_select)
    else $error("sram not selected");
  sector_onehot_a: assert property (
    $onehot0(main_flash_sector_select))
    else $error("several sectors selected");
  sector_zero_a: assert property (
    main_flash_sector_select[0] |-> $past(addr[15:14]) == 2'b00)
    else $error("sector zero outside its range");
  sector_one_a: assert property (
    main_flash_sector_select[1] |-> $past(addr[15:14]) == 2'b01)
    else $error("sector one outside its range");
  upper_page_a: assert property (
    |main_flash_sector_select[7:2] |-> $past(addr[15]) && $past(state.page) < 8'h03)
    else $error("paged sector outside upper half");
  page_gate_a: assert property (
    main_flash_sector_select[4] |-> $past(state.page) == 8'h01)
    else $error("sector four with wrong page");
  seg_onehot_a: assert property (
    $onehot0(secondary_flash_segment_select))
    else $error("several segments selected");
  seg_zero_a: assert property (
    secondary_flash_segment_select[0] |-> $past(addr[15:13]) == 3'b100)
    else $error("segment zero outside its range");
  fetch_gate_a: assert property (
    program_fetch_strobe && !state.routing[RT_MAIN_PRG] |=> !(|main_flash_sector_select))
    else $error("fetch reached main flash");
  fetch_sec_gate_a: assert property (
    program_fetch_strobe && !state.routing[RT_SEC_PRG] |=> !(|secondary_flash_segment_select))
    else $error("fetch reached secondary flash");
  fetch_sram_gate_a: assert property (
    program_fetch_strobe && !state.routing[RT_SRAM_PRG] |=> !sram_select)
    else $error("fetch reached sram");
  data_main_gate_a: assert property (
    cyc == MSD_DATA && !state.routing[RT_MAIN_DAT] |=> !(|main_flash_sector_select))
    else $error("data cycle reached main flash");
  data_sec_gate_a: assert property (
    cyc == MSD_DATA && !state.routing[RT_SEC_DAT] |=> !(|secondary_flash_segment_select))
    else $error("data cycle reached secondary flash");
  fetch_ctrl_a: assert property (
    program_fetch_strobe |=> !ctrl_select && !peripheral_window_select)
    else $error("fetch reached control block");
  page_write_a: assert property (
    reg_wr && reg_addr == OFF_PAGE |=> page_value == $past(reg_wdata))
    else $error("page write lost");
  prog_erase_a: assert property (
    !(flash_byte_program && flash_sector_erase))
    else $error("program and erase together");
  strobe_write_a: assert property (
    flash_byte_program || flash_sector_erase |-> $past(data_wr) && !$past(program_fetch_strobe))
    else $error("flash strobe without data write");
  erase_code_a: assert property (
    flash_sector_erase |-> $past(wdata) == 8'h30)
    else $error("erase without erase command");
  blocked_note_a: assert property (
    blocked_write_s |=> state.wr_blocked)
    else $error("refused write not noted");
endmodule : msd_decoder

// File: core/msd_main_flash_dec.sv
// per-sector main flash select decode
`timescale 1ns/100ps
module msd_main_flash_dec (
  // address and page
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  page,
  // raw sector hits
  output      logic [7:0]  hit
);
  import msd_pkg::*;
  genvar g;
  // ****************************************
  // one decoder per sector
  // ****************************************
  generate
    for (g = 0; g < msd_pkg::NUM_SECT; g++) begin : g_sect
      if (g < 2) begin : g_common
        assign hit[g] = (addr[15:SECT_SHIFT] == 2'(g));
      end else begin : g_paged
        assign hit[g] = (page == 8'((g - 2) / 2)) && addr[15]
                        && (addr[SECT_SHIFT] == 1'((g - 2) % 2));
      end
    end
  endgenerate
endmodule : msd_main_flash_dec

// File: core/msd_pkg.sv
// package of constants for the memory space decoder
package msd_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [15:0] SRAM_LO      = 16'h0000;
  localparam logic [15:0] SRAM_HI      = 16'h1FFF;
  localparam logic [15:0] CTRL_LO      = 16'h2000;
  localparam logic [15:0] CTRL_HI      = 16'h20FF;
  localparam logic [15:0] SEC0_LO      = 16'h0000;
  localparam logic [15:0] SEC0_HI      = 16'h3FFF;
  localparam logic [15:0] SEC1_LO      = 16'h4000;
  localparam logic [15:0] SEC1_HI      = 16'h7FFF;
  localparam logic [15:0] UPPER_LO     = 16'h8000;
  localparam logic [15:0] UPPER_MID    = 16'hBFFF;
  localparam logic [15:0] UPPER_HI2    = 16'hC000;
  localparam logic [15:0] SEG_BASE     = 16'h8000;
  localparam int          SEG_SHIFT    = 13;
  localparam int          SECT_SHIFT   = 14;
  localparam int          NUM_SECT     = 8;
  localparam int          NUM_SEG      = 4;
  localparam int          NUM_SEG_MAP  = 3;
  localparam int          NUM_PAGES    = 3;
  // ****************************************
  // control register block offsets (low byte of address)
  // ****************************************
  localparam logic [7:0]  OFF_ROUTING  = 8'hE2;
  localparam logic [7:0]  OFF_PAGE     = 8'hE0;
  localparam logic [7:0]  OFF_STATUS   = 8'hE4;
  // ****************************************
  // routing register fields
  // ****************************************
  localparam int          RT_SRAM_PRG  = 0;
  localparam int          RT_SEC_PRG   = 1;
  localparam int          RT_MAIN_PRG  = 2;
  localparam int          RT_SEC_DAT   = 3;
  localparam int          RT_MAIN_DAT  = 4;
  localparam int          RT_PERIPHERAL_WINDOW_ENABLE    = 7;
  localparam logic [4:0]  RT_NV_DEFAULT = 5'h0C;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;
  // ****************************************
  // peripheral window range
  // ****************************************
  localparam logic [15:0] PWIN_LO      = 16'h3000;
  localparam logic [15:0] PWIN_HI      = 16'h30FF;
  // bus cycle kinds
  typedef enum logic [1:0] {
    MSD_IDLE  = 2'b00,
    MSD_FETCH = 2'b01,
    MSD_DATA  = 2'b10
  } msd_cycle_t;
endpackage : msd_pkg

// File: tb/msd_core_model.sv
// processor core external bus model facing the memory space decoder
`timescale 1ns/100ps
module msd_core_model (
  // clock
  input  wire logic        clk,
  // core external bus
  output      logic [15:0] addr,
  output      logic        data_rd,
  output      logic        data_wr,
  output      logic        program_fetch_strobe,
  output      logic [7:0]  wdata
);
  // idle bus at time zero
  initial begin
    addr = 16'hFFFF;
    data_rd = 1'b0;
    data_wr = 1'b0;
    program_fetch_strobe = 1'b0;
    wdata = 8'hFF;
  end

  // one bus cycle: kind 1 fetch, 2 data read, 3 data write
  // routing first, then writes only through the data strobe
  task automatic issue(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    program_fetch_strobe <= (k == 1);
    data_rd <= (k == 2);
    data_wr <= (k == 3);
    wdata <= (k == 3) ? d : ~d;
    @(posedge clk);
    program_fetch_strobe <= 1'b0;
    data_rd <= 1'b0;
    data_wr <= 1'b0;
    addr <= ~a; // released lines must not keep the last value
    wdata <= ~d;
  endtask : issue
endmodule : msd_core_model

// File: tb/test_msd_decoder.sv
// self-checking testbench of the memory space decoder
`timescale 1ns/100ps
module test_msd_decoder;
  import msd_pkg::*;
  logic        clk, reset, data_rd, data_wr, program_fetch_strobe, reg_wr, reg_rd;
  logic [15:0] addr;
  logic [7:0]  wdata, reg_addr, reg_wdata, reg_rdata, msel, page_value;
  logic [4:0]  nv_routing;
  logic [3:0]  ssel;
  logic        sram_select, ctrl_select, peripheral_window_select;
  logic        flash_byte_program, flash_sector_erase;
  int          error_cnt, cmp_count, rt, pg, cyc, seed, blk;
  logic [15:0] addrs [18] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h20FF, 16'h2100, 16'h3000,
    16'h30FF, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hBFFF,
    16'hC000, 16'hDFFF, 16'hE000, 16'hFFFF};
  logic [7:0]  rts [8] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h9F, 8'h00, 8'hFF};

  msd_core_model msd_core_model_inst (.clk(clk), .addr(addr), .data_rd(data_rd),
    .data_wr(data_wr), .program_fetch_strobe(program_fetch_strobe), .wdata(wdata));
  msd_decoder msd_decoder_inst (.clk(clk), .reset(reset), .addr(addr), .data_rd(data_rd),
    .data_wr(data_wr), .program_fetch_strobe(program_fetch_strobe), .wdata(wdata),
    .nv_routing(nv_routing), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_flash_sector_select(msel),
    .secondary_flash_segment_select(ssel), .sram_select(sram_select),
    .ctrl_select(ctrl_select), .peripheral_window_select(peripheral_window_select),
    .flash_byte_program(flash_byte_program), .flash_sector_erase(flash_sector_erase),
    .page_value(page_value));

  // clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      final_report;
    end
  end

  // ****************************************
  // reference model
  // ****************************************
  function automatic logic [14:0] exp_sel(int k, logic [15:0] a, int r, int p);
    int m, s, sr, ct, pw;
    m = (a < 16'h4000) ? 1 : 2;
    if (a >= 16'h8000)
      m = (p < 3) ? (1 << (2 + 2 * p + int'(a >= 16'hC000))) : 0;
    s = (a >= 16'h8000 && a < 16'hE000) ? (1 << ((a - 16'h8000) >> 13)) : 0;
    sr = (a < 16'h2000);
    ct = (a >= 16'h2000 && a < 16'h2100);
    pw = (a >= 16'h3000 && a < 16'h3100) && r[7];
    if (k == 1) begin
      sr = sr & r[0];
      ct = 0;
      pw = 0;
      m = r[2] ? m : 0;
      s = r[1] ? s : 0;
    end else begin
      m = r[4] ? m : 0;
      s = r[3] ? s : 0;
    end
    if (s != 0) m = 0;
    if (sr | ct | pw) begin
      m = 0;
      s = 0;
    end
    return {8'(m), 4'(s), 1'(sr), 1'(ct), 1'(pw)};
  endfunction : exp_sel

  // compare and count
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // register port cycle, write or read
  task automatic rw(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : rw

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rw(a, 8'h00, 1'b0);
    check("reg_rdata", 16'(reg_rdata), 16'(e));
  endtask : rd_chk

  // one bus cycle and its selects and strobes
  task automatic bus(input int k, input logic [15:0] a);
    logic [7:0]  d;
    logic [14:0] e;
    logic        fl;
    d = ($random(seed) & 1) ? 8'h30 : 8'($random(seed));
    e = exp_sel(k, a, rt, pg);
    msd_core_model_inst.issue(k, a, d);
    #1;
    check("selects", {1'b0, msel, ssel, sram_select, ctrl_select, peripheral_window_select},
      16'(e));
    fl = (k == 3) && (e[14:3] != 12'h000);
    // a write to the upper half that no flash takes is noted in the status bit
    if (k == 3 && a[15] && e[14:3] == 12'h000) blk = 1;
    check("strobes", {14'h0000, flash_byte_program, flash_sector_erase},
      {14'h0000, fl && d != 8'h30, fl && d == 8'h30});
  endtask : bus

  task automatic final_report;
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'hc931;
    clk = 1'b0;
    reset = 1'b1;
    cyc = 0;
    error_cnt = 0;
    cmp_count = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pg = 0;
    blk = 0;
    nv_routing = 5'($random(seed));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rt = nv_routing;
    rd_chk(OFF_ROUTING, 8'(rt));
    rd_chk(OFF_PAGE, 8'h00);
    foreach (rts[i]) begin
      rw(OFF_ROUTING, rts[i], 1'b1);
      rt = rts[i] & 8'h9F;
      rd_chk(OFF_ROUTING, 8'(rt));
      for (int p = 0; p < 4; p++) begin
        rw(OFF_PAGE, 8'(p), 1'b1);
        pg = p;
        for (int k = 1; k < 4; k++)
          foreach (addrs[j]) bus(k, addrs[j]);
        repeat (20) bus(1 + ({$random(seed)} % 3), 16'($random(seed)));
        check("page_value", 16'(page_value), 16'(p));
        rd_chk(OFF_STATUS, 8'(blk));
        rw(OFF_STATUS, 8'h00, 1'b1);
        blk = 0;
      end
    end
    rd_chk(8'h55, 8'h00);
    // second reset in mid-run reloads routing and drops the window enable
    @(posedge clk);
    reset <= 1'b1;
    nv_routing <= 5'h13;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(OFF_ROUTING, 8'h13);
    rd_chk(OFF_PAGE, 8'h00);
    rd_chk(OFF_STATUS, 8'h00);
    final_report;
  end
endmodule : test_msd_decoder
